// file: common/ppx_map.vh
`ifndef PPX_MAP_VH
`define PPX_MAP_VH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_DATA 11'h000
`define IDX_PORT_CTRL 11'h002
`define IDX_QUEUE 11'h400
`define IDX_CONFIG_A 11'h400
`define IDX_CONFIG_B 11'h401
`define IDX_EXT_CTRL 11'h402
`define IDX_IRQ_STATUS 11'h403
`define IDX_IRQ_CLEAR 11'h404
`define IDX_IRQ_ENABLE 11'h405
// ----------------------------------------
// extended control field positions and modes
// ----------------------------------------
`define ECR_MODE_HI 7
`define ECR_MODE_LO 5
`define ECR_FAULT_DIS 4
`define ECR_XFER_EN 3
`define ECR_SERVICE 2
`define ECR_FULL 1
`define ECR_EMPTY 0
`define ECR_RESET 5'h14
`define MODE_STANDARD 3'h0
`define MODE_BIDIR 3'h1
`define MODE_FIFO 3'h2
`define MODE_EXTENDED 3'h3
`define MODE_ENHANCED 3'h4
`define MODE_RESERVED 3'h5
`define MODE_TEST 3'h6
`define MODE_CONFIG 3'h7
`define PORT_CTRL_DIR 5
`define CONFIG_A_VALUE 8'h10
`define CONFIG_B_IRQ_SEL 3'h0
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_BITS 2
`define IRQ_FAULT 0
`define IRQ_DRAINED 1
// ----------------------------------------
// queue and timing
// ----------------------------------------
`define QUEUE_DEPTH 16
`define QUEUE_AW 4
`define CLK_MHZ 40
`define STROBE_NS 500
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`endif

// file: src/byte_queue.v
`timescale 1ns/1ps
`include "ppx_map.vh"
module byte_queue (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire push,
  input wire [8:0] push_data,
  input wire pop,
  output wire [8:0] pop_data,
  output wire full,
  output wire empty,
  output reg [`QUEUE_AW:0] count
);
  // each entry: bit 8 marks an address/command byte, bits 7:0 the byte
  reg [8:0] mem [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_AW-1:0] wr_ptr;
  reg [`QUEUE_AW-1:0] rd_ptr;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;

  assign full = (count == `QUEUE_DEPTH);
  assign empty = (count == {(`QUEUE_AW+1){1'b0}});
  assign pop_data = mem[rd_ptr];

  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {`QUEUE_AW{1'b0}};
      rd_ptr <= {`QUEUE_AW{1'b0}};
      count <= {(`QUEUE_AW+1){1'b0}};
    end else if (clear) begin
      wr_ptr <= {`QUEUE_AW{1'b0}};
      rd_ptr <= {`QUEUE_AW{1'b0}};
      count <= {(`QUEUE_AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop & ~do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_queue

// file: src/port_extended_control.v
`timescale 1ns/1ps
`include "ppx_map.vh"
module port_extended_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] pd_in,
  output reg [7:0] pd_out,
  output reg pd_oe,
  output reg strobe_n,
  output reg host_ack,
  input wire busy,
  input wire ack_n,
  input wire peripheral_error_n,
  output wire dma_req,
  input wire dma_ack,
  input wire [7:0] dma_wdata,
  output reg [7:0] dma_rdata,
  output wire enhanced_port_active,
  output wire irq
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 6'b000001;
  localparam ST_SETUP = 6'b000010;
  localparam ST_STROBE = 6'b000100;
  localparam ST_HOLD = 6'b001000;
  localparam ST_RECV = 6'b010000;
  localparam ST_RACK = 6'b100000;
  localparam integer STROBE_FULL = `STROBE_CYC;
  localparam [7:0] STROBE_CYC = STROBE_FULL[7:0];
  localparam [4:0] ECR_INIT = `ECR_RESET;
  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  reg [2:0] mode;
  reg fault_irq_disable;
  reg transfer_request_enable;
  reg service_bit;
  reg [7:0] data_reg;
  reg direction;
  reg [`IRQ_BITS-1:0] irq_status;
  reg [`IRQ_BITS-1:0] irq_enable;
  reg [5:0] state;
  reg [7:0] cnt;
  reg fault_q;
  reg [7:0] next_prdata;
  reg next_slverr;
  wire [10:0] idx = paddr[12:2];
  wire access = psel & penable & ~pready;
  wire commit = psel & penable & pready;
  wire wr = commit & pwrite;
  wire rd = commit & ~pwrite;
  wire m_std = (mode == `MODE_STANDARD);
  wire m_fifo = (mode == `MODE_FIFO);
  wire m_ext = (mode == `MODE_EXTENDED);
  wire m_test = (mode == `MODE_TEST);
  wire m_cfg = (mode == `MODE_CONFIG);
  wire m_bidir = (mode == `MODE_BIDIR);
  // queue reachable from software in these modes; config mode takes index 400h over
  wire queue_mapped = m_fifo | m_ext | m_test;
  wire tx_mode = m_fifo | (m_ext & ~direction);
  wire rx_mode = m_ext & direction;
  wire drain_side = rx_mode | (m_test & direction);
  assign enhanced_port_active = (mode == `MODE_ENHANCED);
  // ----------------------------------------
  // byte queue
  // ----------------------------------------
  wire q_full;
  wire q_empty;
  wire [4:0] q_count;
  wire [8:0] q_head;
  wire tx_start = (state == ST_IDLE) & tx_mode & ~q_empty & ~busy;
  wire rx_take = (state == ST_RECV) & ~ack_n;
  wire sw_push = wr & queue_mapped & (idx == `IDX_QUEUE);
  // writes to the data index in forward extended mode go in as address bytes
  wire addr_push = wr & m_ext & ~direction & (idx == `IDX_DATA);
  wire sw_pop = rd & queue_mapped & (idx == `IDX_QUEUE) & (m_test | rx_mode);
  // requests drop while software is on the bus so the two never collide
  wire dma_allowed = transfer_request_enable & ~psel;
  assign dma_req = dma_allowed & ((tx_mode & ~q_full) | (drain_side & ~q_empty));
  wire dma_push = dma_ack & dma_req & tx_mode;
  wire dma_pop = dma_ack & dma_req & drain_side;
  wire q_push = sw_push | addr_push | dma_push | rx_take;
  wire q_pop = tx_start | sw_pop | dma_pop;
  wire [8:0] q_in = rx_take ? {1'b0, pd_in} :
                    dma_push ? {1'b0, dma_wdata} :
                    {addr_push, pwdata[7:0]};
  byte_queue byte_queue_inst (
    .clk(pclk),
    .rst_n(presetn),
    .clear(m_std),
    .push(q_push),
    .push_data(q_in),
    .pop(q_pop),
    .pop_data(q_head),
    .full(q_full),
    .empty(q_empty),
    .count(q_count)
  );
  // ----------------------------------------
  // software register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_STANDARD;
      fault_irq_disable <= ECR_INIT[`ECR_FAULT_DIS];
      transfer_request_enable <= ECR_INIT[`ECR_XFER_EN];
      service_bit <= ECR_INIT[`ECR_SERVICE];
      data_reg <= 8'h00;
      direction <= 1'b0;
      irq_enable <= {`IRQ_BITS{1'b0}};
    end else if (wr) begin
      case (idx)
        `IDX_EXT_CTRL: begin
          // reserved code is refused, the previous mode stays
          if (pwdata[`ECR_MODE_HI:`ECR_MODE_LO] != `MODE_RESERVED) begin
            mode <= pwdata[`ECR_MODE_HI:`ECR_MODE_LO];
          end
          fault_irq_disable <= pwdata[`ECR_FAULT_DIS];
          transfer_request_enable <= pwdata[`ECR_XFER_EN];
          service_bit <= pwdata[`ECR_SERVICE];
        end
        `IDX_DATA: begin
          data_reg <= pwdata[7:0];
        end
        `IDX_PORT_CTRL: begin
          direction <= pwdata[`PORT_CTRL_DIR];
        end
        `IDX_IRQ_ENABLE: begin
          irq_enable <= pwdata[`IRQ_BITS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data and bus answer (one wait state)
  // ----------------------------------------
  always @* begin
    next_prdata = 8'h00;
    next_slverr = 1'b0;
    case (idx)
      `IDX_DATA: begin
        next_prdata = m_bidir ? pd_in : data_reg;
      end
      `IDX_PORT_CTRL: begin
        next_prdata = {2'b00, direction, 5'h00};
      end
      `IDX_EXT_CTRL: begin
        next_prdata = {mode, fault_irq_disable, transfer_request_enable, service_bit,
                       q_full, q_empty};
      end
      `IDX_QUEUE: begin
        if (m_cfg) begin
          next_prdata = `CONFIG_A_VALUE;
        end else if (queue_mapped) begin
          next_prdata = q_empty ? 8'h00 : q_head[7:0];
        end else begin
          next_slverr = 1'b1;
        end
      end
      `IDX_CONFIG_B: begin
        if (m_cfg) begin
          next_prdata = {1'b0, irq, `CONFIG_B_IRQ_SEL, 3'h7};
        end else begin
          next_slverr = 1'b1;
        end
      end
      `IDX_IRQ_STATUS: begin
        next_prdata = {{(8-`IRQ_BITS){1'b0}}, irq_status};
      end
      `IDX_IRQ_CLEAR: begin
        next_prdata = 8'h00;
      end
      `IDX_IRQ_ENABLE: begin
        next_prdata = {{(8-`IRQ_BITS){1'b0}}, irq_enable};
      end
      default: begin
        next_slverr = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access & next_slverr;
      if (access & ~pwrite) begin
        prdata <= {24'h000000, next_prdata};
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // fault input is active low, so the asserting edge is the falling edge
  wire fault_fall = fault_q & ~peripheral_error_n;
  wire [`IRQ_BITS-1:0] irq_event;
  assign irq_event[`IRQ_FAULT] = fault_fall & m_ext & ~fault_irq_disable;
  assign irq_event[`IRQ_DRAINED] = tx_start & (q_count == 5'd1);
  wire clr_wr = wr & (idx == `IDX_IRQ_CLEAR);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b1;
    end else begin
      fault_q <= peripheral_error_n;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `IRQ_BITS; g = g + 1) begin : g_irq
      // a set in the clearing cycle wins, so no event is lost
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_status[g] <= 1'b0;
        end else if (irq_event[g]) begin
          irq_status[g] <= 1'b1;
        end else if (clr_wr & pwdata[g]) begin
          irq_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------
  // port handshake
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      strobe_n <= 1'b1;
      host_ack <= 1'b1;
      pd_out <= 8'h00;
      pd_oe <= 1'b1;
      dma_rdata <= 8'h00;
    end else begin
      // direction releases the lines in every mode except the standard and FIFO ones
      pd_oe <= m_std | (mode == `MODE_FIFO) | ~direction;
      if (dma_pop) begin
        dma_rdata <= q_head[7:0];
      end
      if (state == ST_IDLE || !(tx_mode || rx_mode)) begin
        pd_out <= data_reg;
      end
      // leaving a transfer mode aborts the handshake; the peripheral sees strobe released
      if (!(tx_mode || rx_mode)) begin
        state <= ST_IDLE;
        strobe_n <= 1'b1;
        host_ack <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            if (tx_start) begin
              pd_out <= q_head[7:0];
              host_ack <= ~q_head[8];
              state <= ST_SETUP;
            end else if (rx_mode) begin
              host_ack <= 1'b0;
              state <= ST_RECV;
            end
          end
          ST_SETUP: begin
            strobe_n <= 1'b0;
            cnt <= STROBE_CYC - 8'd1;
            state <= ST_STROBE;
          end
          ST_STROBE: begin
            // FIFO handshake uses a timed strobe, extended waits for busy
            if (m_fifo ? (cnt == 8'h00) : busy) begin
              strobe_n <= 1'b1;
              state <= ST_HOLD;
            end else if (cnt != 8'h00) begin
              cnt <= cnt - 8'd1;
            end
          end
          ST_HOLD: begin
            if (!busy) begin
              host_ack <= 1'b1;
              state <= ST_IDLE;
            end
          end
          ST_RECV: begin
            if (!ack_n) begin
              host_ack <= 1'b1;
              state <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (ack_n) begin
              host_ack <= 1'b0;
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // port_extended_control

// file: verification/port_extended_control_checker.sv
`timescale 1ns/1ps
`include "ppx_map.vh"
module port_extended_control_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire strobe_n,
  input wire peripheral_error_n,
  input wire dma_req,
  input wire enhanced_port_active,
  input wire irq
);
  logic [7:0] ctl;
  logic [1:0] en;
  logic [5:0] low_cnt;
  wire [10:0] idx = paddr[12:2];
  wire done = psel & penable & pready;
  wire rd = done & !pwrite;
  wire [2:0] mode = ctl[7:5];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // shadow of the control bits, built only from bus traffic
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h14;
      en <= 2'h0;
      low_cnt <= 6'h0;
    end else begin
      low_cnt <= strobe_n ? 6'h0 : low_cnt + 6'h1;
      if (done && pwrite && idx == `IDX_EXT_CTRL)
        ctl <= {(pwdata[7:5] == `MODE_RESERVED) ? mode : pwdata[7:5], pwdata[4:0]};
      if (done && pwrite && idx == `IDX_IRQ_ENABLE)
        en <= pwdata[1:0];
    end
  end
  a_mode_readback: assert property (rd && idx == `IDX_EXT_CTRL |->
    prdata[7:3] == ctl[7:3]) else $error("control readback wrong");
  a_std_no_req: assert property (mode == `MODE_STANDARD |-> !dma_req)
    else $error("request in standard mode");
  a_strobe_width: assert property ($rose(strobe_n) && mode == `MODE_FIFO |->
    low_cnt == `STROBE_CYC) else $error("strobe width wrong");
  a_enh_flag: assert property (enhanced_port_active == (mode == `MODE_ENHANCED))
    else $error("enhanced flag wrong");
  a_config_a: assert property (rd && idx == `IDX_CONFIG_A && mode == `MODE_CONFIG |->
    prdata[7:0] == `CONFIG_A_VALUE && !pslverr) else $error("config a wrong");
  a_config_b_gate: assert property (rd && idx == `IDX_CONFIG_B && mode != `MODE_CONFIG |->
    pslverr) else $error("config b visible");
  a_fault_irq: assert property ($fell(peripheral_error_n) && mode == 3'h3 && !ctl[4]
    && en[0] |-> ##[1:6] irq) else $error("fault irq missing");
  a_fault_masked: assert property ($fell(peripheral_error_n) && ctl[4] && !en[1]
    && !irq |=> (!irq)[*4]) else $error("masked fault raised irq");
  a_req_gate: assert property (!ctl[3] |-> !dma_req)
    else $error("request while disabled");
endmodule // port_extended_control_checker
bind port_extended_control port_extended_control_checker port_extended_control_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .strobe_n(strobe_n), .peripheral_error_n(peripheral_error_n), .dma_req(dma_req),
  .enhanced_port_active(enhanced_port_active), .irq(irq)
);

// file: verification/printer_model.sv
`timescale 1ns/1ps
module printer_model (
  input wire pclk,
  input wire strobe_n,
  input wire [7:0] pd_out,
  input wire pd_oe,
  input wire host_ack,
  input wire [3:0] lag,
  output logic busy,
  output logic ack_n,
  output wire [7:0] pd_in
);
  logic [7:0] drv = 8'h0;
  logic own = 1'h0;
  logic [8:0] got [$];
  int n;
  // released lines show the inverse of the last value, never a stale copy
  assign pd_in = pd_oe ? pd_out : (own ? drv : ~drv);
  initial begin
    busy = 1'h0;
    ack_n = 1'h1;
    forever begin
      @(negedge pclk);
      if (strobe_n === 1'h0) begin
        got.push_back({host_ack, pd_in});
        @(posedge pclk);
        repeat (lag) @(posedge pclk);
        busy <= 1'h1;
        for (n = 0; n < 999 && strobe_n !== 1'h1; n++) @(negedge pclk);
        @(posedge pclk);
        repeat (lag) @(posedge pclk);
        busy <= 1'h0;
      end
    end
  end
  task automatic send(input logic [7:0] b);
    int k;
    for (k = 0; k < 99 && host_ack !== 1'h0; k++) @(negedge pclk);
    @(posedge pclk);
    drv <= b;
    own <= 1'h1;
    ack_n <= 1'h0;
    @(negedge pclk);
    for (k = 0; k < 99 && host_ack !== 1'h1; k++) @(negedge pclk);
    @(posedge pclk);
    ack_n <= 1'h1;
    @(posedge pclk);
    own <= 1'h0;
  endtask
  // the bench drives or releases the lines through here so the model stays their only writer
  task automatic show(input logic [7:0] b, input logic on);
    drv <= b;
    own <= on;
  endtask
endmodule // printer_model

// file: verification/parallel_port_extended_control_tb.sv
`timescale 1ns/1ps
`include "ppx_map.vh"
module parallel_port_extended_control_tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [12:0] paddr = 13'h0;
  logic [31:0] pwdata = 32'h0;
  logic dma_ack = 1'h0;
  logic [7:0] dma_wdata = 8'h0;
  logic peripheral_error_n = 1'h1;
  logic [3:0] lag = 4'h0;
  wire [31:0] prdata;
  wire [7:0] pd_in, pd_out, dma_rdata;
  wire pready, pslverr, pd_oe, strobe_n, host_ack, busy, ack_n, dma_req;
  wire enhanced_port_active, irq;
  int failures = 0;
  int tests_run = 0;
  int i, n;
  logic [31:0] seed, wv, rd;
  logic er;
  logic [2:0] em;
  logic [7:0] q [4];
  always #12.5 pclk = ~pclk;
  port_extended_control port_extended_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .strobe_n(strobe_n), .host_ack(host_ack),
    .busy(busy), .ack_n(ack_n), .peripheral_error_n(peripheral_error_n), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
    .enhanced_port_active(enhanced_port_active), .irq(irq)
  );
  printer_model printer_model_inst (
    .pclk(pclk), .strobe_n(strobe_n), .pd_out(pd_out), .pd_oe(pd_oe), .host_ack(host_ack),
    .lag(lag), .busy(busy), .ack_n(ack_n), .pd_in(pd_in)
  );
  // ----
  // bus, compare and closing tasks
  // ----
  task automatic apb(input logic w, input logic [10:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    // read before this edge's updates land, so pready and data are the sampled values
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 40);
    if (k >= 40) stuck();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, x);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic stuck;
    failures++;
    $display("BAD %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic end_sim;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [2:0] next_mode(input logic [2:0] old, req);
    return (req == `MODE_RESERVED) ? old : req;
  endfunction
  initial begin
    seed = 32'hE1F0;
    em = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `IDX_EXT_CTRL, 8'h0);
    chk(rd, 32'h15);
    for (i = 0; i < 8; i++) begin
      wv = $random(seed);
      apb(1'h1, `IDX_EXT_CTRL, {i[2:0], wv[4:0]});
      em = next_mode(em, i[2:0]);
      apb(1'h0, `IDX_EXT_CTRL, 8'h0);
      chk(rd[7:3], {em, wv[4:3]});
      chk(enhanced_port_active, em == `MODE_ENHANCED);
      apb(1'h0, `IDX_CONFIG_B, 8'h0);
      chk(er, em != `MODE_CONFIG);
    end
    apb(1'h0, `IDX_CONFIG_A, 8'h0);
    chk(rd, `CONFIG_A_VALUE);
    $display("done mode sweep");
    apb(1'h1, `IDX_EXT_CTRL, 8'hD4);
    for (i = 0; i < 4; i++) begin
      q[i] = $random(seed);
      apb(1'h1, `IDX_QUEUE, q[i]);
    end
    for (i = 0; i < 4; i++) begin
      apb(1'h0, `IDX_QUEUE, 8'h0);
      chk(rd, q[i]);
    end
    apb(1'h1, `IDX_QUEUE, 8'hA5);
    apb(1'h1, `IDX_EXT_CTRL, 8'h14);
    apb(1'h1, `IDX_EXT_CTRL, 8'hD4);
    apb(1'h0, `IDX_QUEUE, 8'h0);
    chk(rd, 32'h0);
    chk(printer_model_inst.got.size(), 32'h0);
    $display("done test queue");
    lag <= 4'h7;
    apb(1'h1, `IDX_EXT_CTRL, 8'h54);
    @(negedge pclk);
    chk(dma_req, 1'h0);
    apb(1'h1, `IDX_QUEUE, q[0]);
    apb(1'h1, `IDX_QUEUE, q[1]);
    apb(1'h1, `IDX_EXT_CTRL, 8'h5C);
    for (n = 0; n < 50 && dma_req !== 1'h1; n++) @(negedge pclk);
    if (n >= 50) stuck();
    chk(dma_req, 1'h1);
    @(posedge pclk);
    dma_ack <= 1'h1;
    dma_wdata <= q[2];
    @(posedge pclk);
    dma_ack <= 1'h0;
    apb(1'h1, `IDX_EXT_CTRL, 8'h54);
    for (n = 0; n < 900 && printer_model_inst.got.size() < 3; n++) @(negedge pclk);
    if (n >= 900) stuck();
    for (i = 0; i < 3; i++) chk(printer_model_inst.got[i][7:0], q[i]);
    $display("done fifo send");
    lag <= 4'h0;
    printer_model_inst.got.delete();
    apb(1'h1, `IDX_EXT_CTRL, 8'h74);
    apb(1'h1, `IDX_DATA, q[3]);
    apb(1'h1, `IDX_QUEUE, q[0]);
    for (n = 0; n < 400 && printer_model_inst.got.size() < 2; n++) @(negedge pclk);
    if (n >= 400) stuck();
    chk(printer_model_inst.got[0], {1'h0, q[3]});
    chk(printer_model_inst.got[1], {1'h1, q[0]});
    apb(1'h1, `IDX_PORT_CTRL, 8'h20);
    repeat (2) @(negedge pclk);
    chk(pd_oe, 1'h0);
    printer_model_inst.send(q[1]);
    apb(1'h0, `IDX_QUEUE, 8'h0);
    chk(rd, q[1]);
    $display("done extended link");
    apb(1'h1, `IDX_IRQ_ENABLE, 8'h01);
    peripheral_error_n <= 1'h0;
    repeat (8) @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h0, `IDX_IRQ_STATUS, 8'h0);
    chk(rd[0], 1'h0);
    peripheral_error_n <= 1'h1;
    apb(1'h1, `IDX_EXT_CTRL, 8'h64);
    peripheral_error_n <= 1'h0;
    for (n = 0; n < 9 && irq !== 1'h1; n++) @(negedge pclk);
    if (n >= 9) stuck();
    chk(irq, 1'h1);
    apb(1'h1, `IDX_IRQ_ENABLE, 8'h00);
    @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h1, `IDX_IRQ_ENABLE, 8'h01);
    @(negedge pclk);
    chk(irq, 1'h1);
    apb(1'h1, `IDX_IRQ_CLEAR, 8'h01);
    @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h0, 11'h010, 8'h0);
    chk(er, 1'h1);
    $display("done fault irq");
    apb(1'h1, `IDX_EXT_CTRL, 8'h34);
    printer_model_inst.show(q[2], 1'h1);
    apb(1'h0, `IDX_DATA, 8'h0);
    chk(rd, q[2]);
    printer_model_inst.show(q[2], 1'h0);
    apb(1'h1, `IDX_PORT_CTRL, 8'h00);
    apb(1'h1, `IDX_DATA, q[1]);
    apb(1'h0, `IDX_DATA, 8'h0);
    chk(rd, q[1]);
    chk(pd_oe, 1'h1);
    $display("done bidirectional");
    apb(1'h1, `IDX_PORT_CTRL, 8'h20);
    apb(1'h1, `IDX_EXT_CTRL, 8'hDC);
    apb(1'h1, `IDX_QUEUE, q[3]);
    for (n = 0; n < 50 && dma_req !== 1'h1; n++) @(negedge pclk);
    if (n >= 50) stuck();
    @(posedge pclk);
    dma_ack <= 1'h1;
    @(posedge pclk);
    dma_ack <= 1'h0;
    @(negedge pclk);
    chk(dma_rdata, q[3]);
    chk(dma_req, 1'h0);
    $display("done queue drain");
    end_sim();
  end
endmodule // parallel_port_extended_control_tb
